// file: hdl/tsrp_port.sv
// bus slave and register bank of the thermal sensor
// assumes scl_in also clocks the link side; sda is open drain, resolved outside;
// measured_value_in comes from sensor logic on sys_clk_in
module tsrp_port #(
    parameter logic [3:0] TYPE_CODE = 4'h9,      // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'h5A5A, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'hA5C3,  // arbitrary value
    parameter int TMO_CYCLES = tsrp_pkg::TMO_CYC
) (
    // system side
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] measured_value_in,
    output tsrp_pkg::tsrp_cfg_t cfg_out,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // address straps
    input wire logic strap_bit_zero_in,
    input wire logic strap_bit_one_in,
    input wire logic strap_bit_two_in
);
    import tsrp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // system domain: pin sampling, start/stop, timeout
    logic scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, sda_d_ff;
    logic busy_m_ff, busy_s_ff;
    logic frame_clr_ff, link_rst_ff, in_frame_ff;
    logic [TMO_CNT_W-1:0] tmo_cnt_ff;
    logic [15:0] temp_hold_ff;
    tsrp_cfg_t cfg_out_ff;
    logic start_det, stop_det, tmo_hit;
    // link domain state
    tsrp_state_t st_ff;
    logic [3:0] cnt_ff;
    logic [6:0] shift_ff;
    logic [7:0] hi_ff;
    logic [15:0] rd_word_ff;
    logic ack_ff, busy_ff, sda_oe_ff;
    logic [2:0] ptr_ff, strap_m_ff, strap_s_ff;
    tsrp_cfg_t cfg_ff;
    logic [7:0] byte_in, tx_byte;
    logic addr_match, reading, tx_bit, wr_hit, ptr_hit;
    logic [15:0] sel_word;

    // two-flop sampling of the bus lines and the link busy level
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            busy_m_ff <= 1'b0;
            busy_s_ff <= 1'b0;
        end
        else
        begin
            scl_m_ff <= scl_in;
            scl_s_ff <= scl_m_ff;
            sda_m_ff <= sda_in;
            sda_s_ff <= sda_m_ff;
            sda_d_ff <= sda_s_ff;
            busy_m_ff <= busy_ff;
            busy_s_ff <= busy_m_ff;
        end
    end

    // data edges while the clock is high mark frame boundaries
    assign start_det = scl_s_ff && sda_d_ff && !sda_s_ff;
    assign stop_det = scl_s_ff && !sda_d_ff && sda_s_ff;
    assign tmo_hit = !scl_s_ff && (tmo_cnt_ff == TMO_CNT_W'(TMO_CYCLES - 1));

    // clock-low watch; saturates so a stuck line fires only once
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || scl_s_ff)
            tmo_cnt_ff <= '0;
        else if (tmo_cnt_ff != TMO_CNT_W'(TMO_CYCLES))
            tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
    end

    // one-cycle clear of the link side; the bus clock stands at that moment
    always_ff @(posedge sys_clk_in)
    begin
        frame_clr_ff <= sys_rst_in || start_det || stop_det || tmo_hit;
        link_rst_ff <= sys_rst_in;
    end

    // frame level; changes only while scl stands, long before its next edge
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            in_frame_ff <= 1'b0;
        else if (start_det)
            in_frame_ff <= 1'b1;
        else if (stop_det || tmo_hit)
            in_frame_ff <= 1'b0;
    end

    // words cross only while the link side is quiet, so they are stable
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            temp_hold_ff <= '0;
            cfg_out_ff <= CFG_RST;
        end
        else if (!busy_s_ff)
        begin
            temp_hold_ff <= measured_value_in;
            cfg_out_ff <= cfg_ff;
        end
    end

    assign cfg_out = cfg_out_ff;
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: byte engine on the bus clock
    assign byte_in = {shift_ff, sda_in};
    assign addr_match = (byte_in[7:1] == {TYPE_CODE, strap_s_ff});
    assign reading = (st_ff == ST_RHI) || (st_ff == ST_RLO);
    assign tx_byte = (st_ff == ST_RHI) ? rd_word_ff[15:8] : rd_word_ff[7:0];
    assign tx_bit = tx_byte[~cnt_ff[2:0]];
    assign wr_hit = in_frame_ff && (st_ff == ST_WLO) && (cnt_ff == BIT_LAST);
    assign ptr_hit = in_frame_ff && (st_ff == ST_PTR) && (cnt_ff == BIT_LAST);

    // register select for reads
    always_comb
    begin
        unique case (ptr_ff)
            REG_FEAT: sel_word = FEAT_RST;
            REG_SETUP: sel_word = cfg_ff.setup;
            REG_HIGH: sel_word = cfg_ff.high;
            REG_LOW: sel_word = cfg_ff.low;
            REG_CRIT: sel_word = cfg_ff.crit;
            REG_VALUE: sel_word = temp_hold_ff;
            REG_MAKER: sel_word = MAKER_CODE;
            REG_PART: sel_word = PART_CODE;
        endcase
    end

    // straps are static; sampled twice before the compare
    always_ff @(posedge scl_in or posedge link_rst_ff)
    begin
        if (link_rst_ff)
        begin
            strap_m_ff <= '0;
            strap_s_ff <= '0;
        end
        else
        begin
            strap_m_ff <= {strap_bit_two_in, strap_bit_one_in, strap_bit_zero_in};
            strap_s_ff <= strap_m_ff;
        end
    end

    // byte phases; every start, stop or timeout restarts here
    always_ff @(posedge scl_in or posedge frame_clr_ff)
    begin
        if (frame_clr_ff)
        begin
            st_ff <= ST_ADDR;
            cnt_ff <= '0;
            shift_ff <= '0;
            hi_ff <= '0;
            rd_word_ff <= '0;
            ack_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else if (in_frame_ff)
        begin
            busy_ff <= 1'b1;
            if (cnt_ff == BIT_ACK)
            begin
                cnt_ff <= '0;
                ack_ff <= 1'b0;
                // ack_ff high marks our own address ack, not a host ack of read data
                if (reading && !ack_ff)
                    st_ff <= (sda_in || st_ff == ST_RLO) ? ST_IGN : ST_RLO;
            end
            else
            begin
                cnt_ff <= cnt_ff + 1'b1;
                shift_ff <= byte_in[6:0];
                if (cnt_ff == BIT_LAST)
                begin
                    unique case (st_ff)
                        ST_ADDR:
                        begin
                            ack_ff <= addr_match;
                            rd_word_ff <= sel_word;
                            if (!addr_match)
                                st_ff <= ST_IGN;
                            else
                                st_ff <= byte_in[0] ? ST_RHI : ST_PTR;
                        end
                        ST_PTR:
                        begin
                            ack_ff <= 1'b1;
                            st_ff <= ST_WHI;
                        end
                        ST_WHI:
                        begin
                            ack_ff <= 1'b1;
                            hi_ff <= byte_in;
                            st_ff <= ST_WLO;
                        end
                        ST_WLO:
                        begin
                            ack_ff <= 1'b1;
                            st_ff <= ST_IGN;
                        end
                        ST_IGN, ST_RHI, ST_RLO:
                            st_ff <= st_ff;
                        default:
                            st_ff <= ST_IGN;
                    endcase
                end
            end
        end
    end

    // pointer and writable bank; survive frames, cleared only by reset
    always_ff @(posedge scl_in or posedge link_rst_ff)
    begin
        if (link_rst_ff)
        begin
            ptr_ff <= PTR_RST;
            cfg_ff <= CFG_RST;
        end
        else if (ptr_hit)
            ptr_ff <= byte_in[PTR_SEL_W-1:0];
        else if (wr_hit)
        begin
            // read-only selects fall through untouched
            unique case (ptr_ff)
                REG_SETUP: cfg_ff.setup <= {hi_ff, byte_in};
                REG_HIGH: cfg_ff.high <= {hi_ff, byte_in};
                REG_LOW: cfg_ff.low <= {hi_ff, byte_in};
                REG_CRIT: cfg_ff.crit <= {hi_ff, byte_in};
                default: cfg_ff <= cfg_ff;
            endcase
        end
    end

    // data changes on the falling edge; only sda is ever pulled, never scl
    always_ff @(negedge scl_in or posedge frame_clr_ff)
    begin
        if (frame_clr_ff)
            sda_oe_ff <= 1'b0;
        else if (!in_frame_ff)
            sda_oe_ff <= 1'b0;
        else if (cnt_ff == BIT_ACK)
            sda_oe_ff <= ack_ff;
        else
            sda_oe_ff <= reading && !tx_bit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // clock-low run length for the window checks; runs past the watch up to the late bound
    localparam int LATE_CYC = TMO_CYCLES / TMO_MIN_MS * TMO_MAX_MS;
    localparam logic [TMO_CNT_W:0] LOW_EARLY = (TMO_CNT_W+1)'(TMO_CYCLES - 1);
    localparam logic [TMO_CNT_W:0] LOW_LATE = (TMO_CNT_W+1)'(LATE_CYC);
    logic [TMO_CNT_W:0] low_run_ff;

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || scl_s_ff)
            low_run_ff <= '0;
        else if (low_run_ff != LOW_LATE)
            low_run_ff <= low_run_ff + 1'b1;
    end

    addr_nak_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (in_frame_ff && st_ff == ST_ADDR && cnt_ff == BIT_LAST && !addr_match)
        |=> (!ack_ff && st_ff == ST_IGN) [*8])
        else $error("foreign address acknowledged");

    addr_ack_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (in_frame_ff && st_ff == ST_ADDR && cnt_ff == BIT_LAST && addr_match)
        |=> ack_ff && cnt_ff == BIT_ACK)
        else $error("own address not acknowledged");

    ptr_load_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        ptr_hit |=> ptr_ff == $past(byte_in[2:0]) && st_ff == ST_WHI)
        else $error("pointer not loaded from pointer byte");

    ro_keep_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (wr_hit && (ptr_ff == REG_FEAT || ptr_ff >= REG_VALUE)) |=> $stable(cfg_ff))
        else $error("read-only select changed the bank");

    word_order_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (wr_hit && ptr_ff == REG_HIGH) |=> cfg_ff.high == {$past(hi_ff), $past(byte_in)})
        else $error("word not stored high byte first");

    two_bytes_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        wr_hit |=> st_ff == ST_IGN ##9 !ack_ff)
        else $error("third data byte accepted");

    read_order_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (st_ff == ST_RHI && cnt_ff == BIT_ACK && !ack_ff && !sda_in)
        |=> st_ff == ST_RLO && cnt_ff == 4'h0)
        else $error("low byte does not follow acked high byte");

    msb_first_a: assert property (@(posedge scl_in) disable iff (frame_clr_ff || link_rst_ff)
        (in_frame_ff && reading && cnt_ff < BIT_ACK) |-> sda_oe_ff == !tx_byte[~cnt_ff[2:0]])
        else $error("read bit out of msb-first order");

    tmo_fire_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        tmo_hit |=> frame_clr_ff && !in_frame_ff ##1 !sda_oe_out)
        else $error("timeout did not clear and release");

    tmo_run_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (!scl_s_ff && $past(!scl_s_ff) && tmo_cnt_ff < TMO_CNT_W'(TMO_CYCLES))
        |=> tmo_cnt_ff == $past(tmo_cnt_ff) + 1'b1 || scl_s_ff)
        else $error("timeout watch not counting");

    tmo_win_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        tmo_hit |-> low_run_ff >= LOW_EARLY && low_run_ff < LOW_LATE)
        else $error("timeout outside its window");

    tmo_late_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (low_run_ff == LOW_LATE) |-> !in_frame_ff && !sda_oe_out)
        else $error("clock low past the late bound without release");

    idle_release_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (!in_frame_ff && $past(!in_frame_ff)) |-> !sda_oe_out)
        else $error("data pulled outside a frame");

    rd_done_c: cover property (@(posedge scl_in) st_ff == ST_RLO && cnt_ff == BIT_ACK);
    host_ack_c: cover property (@(posedge scl_in) st_ff == ST_RHI && cnt_ff == BIT_ACK && !ack_ff);
    wr_done_c: cover property (@(posedge scl_in) wr_hit && ptr_ff == REG_CRIT);
    tmo_c: cover property (@(posedge sys_clk_in) tmo_hit);
    nak_c: cover property (@(posedge scl_in) st_ff == ST_ADDR && cnt_ff == BIT_LAST && !addr_match);
endmodule

// file: hdl/tsrp_pkg.sv
// constants, types and states of the thermal sensor bus register port
// assumes a 250 MHz system clock and a bus clock of 10 kHz to 400 kHz
// Function
// - answer a 7-bit address: 4-bit type code then three strap bits, R/W last
// - clock held low over 25 ms resets the bus logic and frees data
// - timeout watch runs from reset, no register write needed
// - timeout fires no sooner than 25 ms, no later than 50 ms
// - select 0 to 7 picks flags, setup, high, low, critical, value, maker, part
// - setup and three limits are read/write; the rest are read-only
// - pointer is loaded first; later data acts on the selected register
// - write is address, pointer, then exactly two data bytes
// - read after address alone returns two bytes from the latched pointer
// - bytes move msb first; ack or nack after the last read byte
// - the port never holds the clock line low
package tsrp_pkg;
    // timing
    localparam int SYS_CLK_KHZ = 250000;
    localparam int TMO_MIN_MS = 25;
    localparam int TMO_MAX_MS = 50;
    localparam int TMO_CYC = TMO_MIN_MS * SYS_CLK_KHZ;
    localparam int TMO_MAX_CYC = TMO_MAX_MS * SYS_CLK_KHZ;
    localparam int TMO_CNT_W = 24;
    // byte framing
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int PTR_SEL_W = 3;
    // register selects
    localparam logic [2:0] REG_FEAT = 3'h0;
    localparam logic [2:0] REG_SETUP = 3'h1;
    localparam logic [2:0] REG_HIGH = 3'h2;
    localparam logic [2:0] REG_LOW = 3'h3;
    localparam logic [2:0] REG_CRIT = 3'h4;
    localparam logic [2:0] REG_VALUE = 3'h5;
    localparam logic [2:0] REG_MAKER = 3'h6;
    localparam logic [2:0] REG_PART = 3'h7;
    // reset values
    localparam logic [2:0] PTR_RST = 3'h0;
    localparam logic [15:0] FEAT_RST = 16'h002F;
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    // writable register bank
    typedef struct packed {
        logic [15:0] setup;
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] crit;
    } tsrp_cfg_t;
    localparam tsrp_cfg_t CFG_RST = '{SETUP_RST, LIMIT_RST, LIMIT_RST, LIMIT_RST};
    // byte phases of a frame
    typedef enum logic [2:0] {
        ST_ADDR = 3'b000,
        ST_PTR = 3'b001,
        ST_WHI = 3'b011,
        ST_WLO = 3'b010,
        ST_IGN = 3'b110,
        ST_RHI = 3'b111,
        ST_RLO = 3'b101
    } tsrp_state_t;
endpackage

// file: verification/tsrp_host_model.sv
// bus host model: drives the bus clock and pulls the data line low
// assumes a pull-up outside, so data reads high when nobody pulls
module tsrp_host_model (
    // bus lines
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock stands high, data released
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // start from idle: data falls while the clock is high
    task automatic start();
        sda_pull_out = 1'b1;
        #16 scl_out = 1'b0;
        #8;
    endtask
    // repeated start, entered with the clock low
    task automatic rstart();
        sda_pull_out = 1'b0;
        #8 scl_out = 1'b1;
        #16 sda_pull_out = 1'b1;
        #16 scl_out = 1'b0;
        #8;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        sda_pull_out = 1'b1;
        #8 scl_out = 1'b1;
        #16 sda_pull_out = 1'b0;
        #16;
    endtask
    // byte out msb first; data only moves while the clock is low
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_pull_out = ~b[i];
            #8 scl_out = 1'b1;
            #16 scl_out = 1'b0;
            #8;
        end
        sda_pull_out = 1'b0;
        #8 scl_out = 1'b1;
        #8 ack = sda_in;
        #8 scl_out = 1'b0;
        #8;
    endtask
    // byte in msb first, then our ack or nack
    task automatic rbyte(input logic nack, output logic [7:0] b);
        sda_pull_out = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #8 scl_out = 1'b1;
            #8 b[i] = sda_in;
            #8 scl_out = 1'b0;
            #8;
        end
        sda_pull_out = ~nack;
        #8 scl_out = 1'b1;
        #16 scl_out = 1'b0;
        #8;
    endtask
endmodule

// file: verification/tsrp_port_tb.sv
// self-checking bench of the thermal sensor bus register port
// assumes the host model above and a pull-up on the data line
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module tsrp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tsrp_pkg::*;
    localparam logic [3:0] TYPE = 4'h9; // arbitrary value
    localparam logic [15:0] MAKER = 16'h5A5A; // arbitrary value
    localparam logic [15:0] PART = 16'hA5C3; // arbitrary value
    localparam logic [2:0] STRAPS = 3'h5;
    localparam logic [15:0] MEAS = 16'h0191;
    typedef struct {logic [2:0] sel; logic [15:0] wdata; logic [15:0] exp;} tsrp_row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] measured = MEAS;
    tsrp_cfg_t cfg;
    logic scl, sda, dev_sda, sda_oe, host_pull;
    logic [15:0] got;
    int compares = 0;
    int n_mismatch = 0;
    tsrp_row_t rows [8] = '{'{REG_FEAT, 16'hFFFF, FEAT_RST}, '{REG_SETUP, 16'h1234, 16'h1234},
        '{REG_HIGH, 16'h0550, 16'h0550}, '{REG_LOW, 16'h8001, 16'h8001},
        '{REG_CRIT, 16'hFFFF, 16'hFFFF}, '{REG_VALUE, 16'h0000, MEAS},
        '{REG_MAKER, 16'h0000, MAKER}, '{REG_PART, 16'hFFFF, PART}};
    // open-drain data: low when either party pulls
    assign sda = ~(host_pull | (sda_oe & ~dev_sda));
    ////////////////////////////////////////////////////////////////////////
    tsrp_port #(.TYPE_CODE(TYPE), .MAKER_CODE(MAKER), .PART_CODE(PART), .TMO_CYCLES(200))
    tsrp_port_inst (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .measured_value_in(measured),
        .cfg_out(cfg), .scl_in(scl), .sda_in(sda), .sda_out(dev_sda), .sda_oe_out(sda_oe),
        .strap_bit_zero_in(STRAPS[0]), .strap_bit_one_in(STRAPS[1]),
        .strap_bit_two_in(STRAPS[2]));
    tsrp_host_model tsrp_host_model_inst (.sda_in(sda), .scl_out(scl), .sda_pull_out(host_pull));
    ////////////////////////////////////////////////////////////////////////
    // system clock, 4 ns period
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    // reset held 4 cycles, released just after an edge
    task automatic do_reset();
        @(posedge sys_clk) #1 sys_rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1; // bus moves start just after an edge, never on one
    endtask
    // write frame with nb data bytes; a third byte must be refused
    task automatic put_word(input logic [7:0] ptr, input logic [15:0] d, input int nb);
        logic ack;
        logic [7:0] b [3];
        b = '{d[15:8], d[7:0], 8'h5A};
        tsrp_host_model_inst.start();
        tsrp_host_model_inst.wbyte({TYPE, STRAPS, 1'b0}, ack);
        `CHK("address ack", 1'b0, ack)
        tsrp_host_model_inst.wbyte(ptr, ack);
        `CHK("pointer ack", 1'b0, ack)
        for (int i = 0; i < nb; i++)
        begin
            tsrp_host_model_inst.wbyte(b[i], ack);
            `CHK("data ack", (i > 1), ack)
        end
        tsrp_host_model_inst.stop();
    endtask
    // read frame, optionally moving the pointer first through a repeated start
    task automatic get_word(input logic set_ptr, input logic [7:0] ptr, input logic nack,
        output logic [15:0] d);
        logic ack;
        tsrp_host_model_inst.start();
        if (set_ptr)
        begin
            tsrp_host_model_inst.wbyte({TYPE, STRAPS, 1'b0}, ack);
            tsrp_host_model_inst.wbyte(ptr, ack);
            tsrp_host_model_inst.rstart();
        end
        tsrp_host_model_inst.wbyte({TYPE, STRAPS, 1'b1}, ack);
        `CHK("read address ack", 1'b0, ack)
        tsrp_host_model_inst.rbyte(1'b0, d[15:8]);
        tsrp_host_model_inst.rbyte(nack, d[7:0]);
        tsrp_host_model_inst.stop();
        `CHK("data released", 1'b0, sda_oe)
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 60 us
    initial
    begin
        #100000;
        n_mismatch++;
        $display("watchdog expired");
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence: table of registers first, then hand-written cases
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            put_word({5'h00, rows[i].sel}, rows[i].wdata, 2);
            get_word(1'b1, {5'h00, rows[i].sel}, i[0], got);
            `CHK("register word", rows[i].exp, got)
        end
        repeat (10) @(posedge sys_clk);
        `CHK("bank copy", {16'h1234, 16'h0550, 16'h8001, 16'hFFFF}, cfg)
        $display("register table test done");
        // surplus third byte is refused and dropped
        put_word({5'h00, REG_HIGH}, 16'h2468, 3);
        get_word(1'b1, {5'h00, REG_HIGH}, 1'b1, got);
        `CHK("limit after surplus byte", 16'h2468, got)
        $display("surplus byte test done");
        // pointer-only write, then two reads by address alone
        put_word({5'h00, REG_VALUE}, 16'h0000, 0);
        for (int i = 0; i < 2; i++)
        begin
            get_word(1'b0, 8'h00, 1'b1, got);
            `CHK("latched pointer read", MEAS, got)
        end
        $display("latched pointer test done");
        // foreign type code and foreign straps get no ack
        foreach (rows[i])
        begin
            logic ack;
            if (i < 2)
            begin
                tsrp_host_model_inst.start();
                tsrp_host_model_inst.wbyte(i ? {TYPE, 3'h4, 1'b0} : {4'h8, STRAPS, 1'b0}, ack);
                `CHK("foreign address ack", 1'b1, ack)
                tsrp_host_model_inst.stop();
            end
        end
        $display("foreign address test done");
        // clock held low mid-read: data released inside the timeout window
        begin
            logic ack;
            tsrp_host_model_inst.start();
            tsrp_host_model_inst.wbyte({TYPE, STRAPS, 1'b1}, ack);
            #600;
            `CHK("driving before timeout", 1'b1, sda_oe)
            #900;
            `CHK("released after timeout", 1'b0, sda_oe)
            #200; // stay low past the late bound so that bound is watched too
            tsrp_host_model_inst.stop();
        end
        get_word(1'b0, 8'h00, 1'b1, got);
        `CHK("read after timeout", MEAS, got)
        $display("timeout test done");
        // second reset brings pointer and bank back
        do_reset();
        get_word(1'b0, 8'h00, 1'b1, got);
        `CHK("pointer after reset", FEAT_RST, got)
        get_word(1'b1, {5'h00, REG_SETUP}, 1'b0, got);
        `CHK("setup after reset", SETUP_RST, got)
        `CHK("bank after reset", CFG_RST, cfg)
        $display("reset test done");
        wrap_up();
    end
endmodule
